// ---- common/tho_pkg.sv ----
// Purpose: constants, types and time conversion for trigger holdoff and out pulse
// Assumes: 200 MHz sys_clk; time registers count in 4 ns units
// Notes: factor register counts in thousandths
package tho_pkg;
    localparam int CLK_PS = 5000;
    localparam int TU_PS = 4000;
    localparam int FACT_DIV = 1000;
    localparam int DLY_MIN_NS = 600;
    localparam logic [31:0] DLY_MIN_CYC = 32'((DLY_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam longint HOLD_MAX_PS = 64'd10000000000000;
    localparam logic [31:0] HOLD_MAX_CYC = 32'(HOLD_MAX_PS / CLK_PS);
    // register byte offsets
    localparam logic [5:0] A_CTRL = 6'h00;
    localparam logic [5:0] A_HTIME = 6'h04;
    localparam logic [5:0] A_HEVENTS = 6'h08;
    localparam logic [5:0] A_HMAX = 6'h0C;
    localparam logic [5:0] A_HMIN = 6'h10;
    localparam logic [5:0] A_HFACT = 6'h14;
    localparam logic [5:0] A_HSCALE = 6'h18;
    localparam logic [5:0] A_ODELAY = 6'h1C;
    localparam logic [5:0] A_OPLEN = 6'h20;
    localparam logic [5:0] A_STATUS = 6'h24;
    // control field positions
    localparam int CF_HMODE = 0;
    localparam int CF_OEN = 3;
    localparam int CF_OSRC = 4;
    localparam int CF_OPOL = 6;
    // reset values
    localparam logic [31:0] RST_HTIME = 32'h0003D090;
    localparam logic [31:0] RST_HEVENTS = 32'h00000001;
    localparam logic [31:0] RST_HMAX = 32'h0007A120;
    localparam logic [31:0] RST_HMIN = 32'h0003D090;
    localparam logic [31:0] RST_HFACT = 32'h000001F4;
    localparam logic [31:0] RST_HSCALE = 32'h000003E8;
    localparam logic [31:0] RST_ODELAY = 32'h000000C8;
    localparam logic [31:0] RST_OPLEN = 32'h00000018;
    localparam logic [31:0] RST_LFSR = 32'hACE10001;
    localparam logic [31:0] LFSR_TAPS = 32'h80200003;

    typedef enum logic [2:0] {HM_OFF = 3'h0, HM_TIME = 3'h1, HM_EVENTS = 3'h2,
        HM_RANDOM = 3'h3, HM_AUTO = 3'h4} tho_hmode_type;
    typedef enum logic [1:0] {OUT_START_AT_TRIGGER_POINT = 2'h0, OS_WAIT = 2'h1,
        OS_POST = 2'h2} tho_osrc_type;
    typedef enum logic [1:0] {OST_IDLE = 2'b00, OST_DELAY = 2'b01,
        OST_PULSE = 2'b11} tho_ost_type;

    typedef struct packed {
        tho_hmode_type hmode;
        logic oen;
        tho_osrc_type osrc;
        logic opol;
        logic [31:0] htime;
        logic [31:0] hevents;
        logic [31:0] hmax;
        logic [31:0] hmin;
        logic [31:0] hfact;
        logic [31:0] hscale;
        logic [31:0] odelay;
        logic [31:0] out_pulse_length;
    } tho_cfg_type;

    typedef struct packed {
        tho_cfg_type cfg;
        logic wait_n;
        logic [31:0] rdata;
        logic [31:0] htmr;
        logic [31:0] hcnt;
        logic [31:0] lfsr;
        tho_ost_type ost;
        logic [31:0] ocnt;
        logic pin;
        logic tout;
        logic acq_prev;
    } tho_state_type;

    // 4 ns units to clock cycles, nearest, at least one
    function automatic logic [31:0] to_cyc(input logic [31:0] t);
        logic [63:0] c;
        c = (64'(t) * 64'(TU_PS) + 64'(CLK_PS / 2)) / 64'(CLK_PS);
        if (c == 64'h0)
            c = 64'h1;
        return c[31:0];
    endfunction

    // factor times horizontal scale, in cycles, capped at 10 s
    function automatic logic [31:0] auto_cyc(input logic [31:0] f, input logic [31:0] s);
        logic [63:0] c;
        c = (64'(f) * 64'(s) * 64'(TU_PS) + 64'(FACT_DIV * CLK_PS / 2))
            / 64'(FACT_DIV * CLK_PS);
        if (c > 64'(HOLD_MAX_CYC))
            c = 64'(HOLD_MAX_CYC);
        if (c == 64'h0)
            c = 64'h1;
        return c[31:0];
    endfunction
endpackage

// ---- design/tho_trigger_qual.sv ----
// Purpose: trigger holdoff qualifier and rear trigger-out pulse generator
// Assumes: trigger events and acquisition marks synchronous to sys_clk
// Notes: registers over Avalon-MM, one wait state per access
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module tho_trigger_qual
    import tho_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic out_start_at_trigger_point_in,
    input wire logic acq_wait,
    input wire logic post_done,
    output logic out_start_at_trigger_point_out,
    output logic out_start_at_trigger_point_out_pin
);
    tho_state_type s_q;
    tho_state_type s_d;
    logic hold_ok;
    logic accept;
    logic start;
    logic wr_go;
    logic [31:0] min_c;
    logic [31:0] max_c;
    logic [31:0] span;
    logic [31:0] rnd_c;
    logic [31:0] dly_c;
    logic [31:0] len_c;
    logic [31:0] ctrl_rd;
    logic [31:0] wmask;

    // byte lanes that a write may touch
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end

    // converted times, redone whenever software changes a setting
    always_comb
    begin
        min_c = to_cyc(s_q.cfg.hmin);
        max_c = to_cyc(s_q.cfg.hmax);
        span = (max_c > min_c) ? max_c - min_c : 32'h0;
        rnd_c = min_c + 32'((48'(span) * 48'(s_q.lfsr[15:0])) >> 16);
        dly_c = to_cyc(s_q.cfg.odelay);
        if (dly_c < DLY_MIN_CYC)
            dly_c = DLY_MIN_CYC;
        len_c = to_cyc(s_q.cfg.out_pulse_length);
        ctrl_rd = 32'h0;
        ctrl_rd[CF_HMODE +: 3] = s_q.cfg.hmode;
        ctrl_rd[CF_OEN] = s_q.cfg.oen;
        ctrl_rd[CF_OSRC +: 2] = s_q.cfg.osrc;
        ctrl_rd[CF_OPOL] = s_q.cfg.opol;
    end

    // holdoff gate and start event selection
    always_comb
    begin
        unique case (s_q.cfg.hmode)
            HM_OFF: hold_ok = 1'b1;
            HM_EVENTS: hold_ok = (s_q.hcnt + 32'h1 >= s_q.cfg.hevents);
            HM_TIME, HM_RANDOM, HM_AUTO: hold_ok = (s_q.htmr == 32'h0);
            default: hold_ok = 1'b1;
        endcase
        accept = out_start_at_trigger_point_in && hold_ok;
        unique case (s_q.cfg.osrc)
            OUT_START_AT_TRIGGER_POINT: start = accept;
            OS_WAIT: start = acq_wait && !s_q.acq_prev;
            OS_POST: start = post_done;
            default: start = 1'b0;
        endcase
        wr_go = avs_write && !s_q.wait_n;
    end

    // next state: bus, holdoff, pulse generator
    always_comb
    begin
        s_d = s_q;
        // one wait state: data latched, then sampled with waitrequest low
        s_d.wait_n = !((avs_read || avs_write) && s_q.wait_n);
        if ((avs_read || avs_write) && s_q.wait_n)
        begin
            unique case (avs_address)
                A_CTRL: s_d.rdata = ctrl_rd;
                A_HTIME: s_d.rdata = s_q.cfg.htime;
                A_HEVENTS: s_d.rdata = s_q.cfg.hevents;
                A_HMAX: s_d.rdata = s_q.cfg.hmax;
                A_HMIN: s_d.rdata = s_q.cfg.hmin;
                A_HFACT: s_d.rdata = s_q.cfg.hfact;
                A_HSCALE: s_d.rdata = s_q.cfg.hscale;
                A_ODELAY: s_d.rdata = s_q.cfg.odelay;
                A_OPLEN: s_d.rdata = s_q.cfg.out_pulse_length;
                A_STATUS: s_d.rdata = {s_q.hcnt[27:0], s_q.pin, s_q.ost,
                    (s_q.htmr != 32'h0)};
                default: s_d.rdata = 32'h0;
            endcase
        end
        if (wr_go)
        begin
            unique case (avs_address)
                A_CTRL:
                begin
                    if (avs_byteenable[0])
                    begin
                        s_d.cfg.hmode = tho_hmode_type'(avs_writedata[CF_HMODE +: 3]);
                        s_d.cfg.oen = avs_writedata[CF_OEN];
                        s_d.cfg.osrc = tho_osrc_type'(avs_writedata[CF_OSRC +: 2]);
                        s_d.cfg.opol = avs_writedata[CF_OPOL];
                    end
                end
                A_HTIME: s_d.cfg.htime = (s_q.cfg.htime & ~wmask) | (avs_writedata & wmask);
                A_HEVENTS: s_d.cfg.hevents = (s_q.cfg.hevents & ~wmask)
                    | (avs_writedata & wmask);
                A_HMAX: s_d.cfg.hmax = (s_q.cfg.hmax & ~wmask) | (avs_writedata & wmask);
                A_HMIN: s_d.cfg.hmin = (s_q.cfg.hmin & ~wmask) | (avs_writedata & wmask);
                A_HFACT: s_d.cfg.hfact = (s_q.cfg.hfact & ~wmask) | (avs_writedata & wmask);
                A_HSCALE: s_d.cfg.hscale = (s_q.cfg.hscale & ~wmask)
                    | (avs_writedata & wmask);
                A_ODELAY: s_d.cfg.odelay = (s_q.cfg.odelay & ~wmask)
                    | (avs_writedata & wmask);
                A_OPLEN: s_d.cfg.out_pulse_length = (s_q.cfg.out_pulse_length & ~wmask)
                    | (avs_writedata & wmask);
                default: s_d.cfg = s_q.cfg;
            endcase
        end

        // free-running source of random holdoff times
        s_d.lfsr = s_q.lfsr[0] ? ((s_q.lfsr >> 1) ^ LFSR_TAPS) : (s_q.lfsr >> 1);

        // holdoff timer restarts on every accepted trigger
        s_d.tout = accept;
        // timer holds the cycles still blocked, so a period of N reopens N cycles on
        if (accept)
        begin
            unique case (s_q.cfg.hmode)
                HM_TIME: s_d.htmr = to_cyc(s_q.cfg.htime) - 32'h1;
                HM_AUTO: s_d.htmr = auto_cyc(s_q.cfg.hfact, s_q.cfg.hscale) - 32'h1;
                HM_RANDOM: s_d.htmr = rnd_c - 32'h1;
                default: s_d.htmr = 32'h0;
            endcase
        end
        else if (s_q.htmr != 32'h0)
            s_d.htmr = s_q.htmr - 32'h1;
        // event counter: counts events since the last passed trigger
        if (s_q.cfg.hmode != HM_EVENTS || accept)
            s_d.hcnt = 32'h0;
        else if (out_start_at_trigger_point_in)
            s_d.hcnt = s_q.hcnt + 32'h1;

        // pulse generator; a start while busy is ignored, not queued
        s_d.acq_prev = acq_wait;
        unique case (s_q.ost)
            OST_IDLE:
            begin
                if (start && s_q.cfg.oen)
                begin
                    s_d.ost = OST_DELAY;
                    s_d.ocnt = dly_c - 32'h1;
                end
            end
            OST_DELAY:
            begin
                if (s_q.ocnt == 32'h0)
                begin
                    s_d.ost = OST_PULSE;
                    s_d.ocnt = len_c - 32'h1;
                end
                else
                    s_d.ocnt = s_q.ocnt - 32'h1;
            end
            OST_PULSE:
            begin
                if (s_q.ocnt == 32'h0)
                    s_d.ost = OST_IDLE;
                else
                    s_d.ocnt = s_q.ocnt - 32'h1;
            end
            default: s_d.ost = OST_IDLE;
        endcase
        // disabling drops any pulse in flight so the pin returns idle at once
        if (!s_q.cfg.oen)
            s_d.ost = OST_IDLE;
        s_d.pin = (s_d.ost == OST_PULSE) ^ s_d.cfg.opol;
    end

    // single state register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.cfg.hmode <= HM_OFF;
            s_q.cfg.osrc <= OUT_START_AT_TRIGGER_POINT;
            s_q.cfg.htime <= RST_HTIME;
            s_q.cfg.hevents <= RST_HEVENTS;
            s_q.cfg.hmax <= RST_HMAX;
            s_q.cfg.hmin <= RST_HMIN;
            s_q.cfg.hfact <= RST_HFACT;
            s_q.cfg.hscale <= RST_HSCALE;
            s_q.cfg.odelay <= RST_ODELAY;
            s_q.cfg.out_pulse_length <= RST_OPLEN;
            s_q.wait_n <= 1'b1;
            s_q.lfsr <= RST_LFSR;
            s_q.ost <= OST_IDLE;
        end
        else
            s_q <= s_d;
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.wait_n;
    assign out_start_at_trigger_point_out = s_q.tout;
    assign out_start_at_trigger_point_out_pin = s_q.pin;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_off_passes: assert property (
        s_q.cfg.hmode == HM_OFF && out_start_at_trigger_point_in |=> out_start_at_trigger_point_out)
        else $error("trigger lost with holdoff off");
    chk_hold_drops: assert property (
        s_q.cfg.hmode == HM_TIME && s_q.htmr != 32'h0 && out_start_at_trigger_point_in |=> !out_start_at_trigger_point_out)
        else $error("trigger passed during holdoff");
    chk_time_reload: assert property (
        s_q.cfg.hmode == HM_TIME && out_start_at_trigger_point_in && s_q.htmr == 32'h0
        |=> s_q.htmr == to_cyc($past(s_q.cfg.htime)) - 32'h1 && out_start_at_trigger_point_out)
        else $error("fixed holdoff not restarted");
    chk_auto_load: assert property (
        s_q.cfg.hmode == HM_AUTO && accept
        |=> s_q.htmr == auto_cyc($past(s_q.cfg.hfact), $past(s_q.cfg.hscale)) - 32'h1)
        else $error("auto holdoff wrong");
    chk_event_skip: assert property (
        s_q.cfg.hmode == HM_EVENTS && out_start_at_trigger_point_in && s_q.hcnt + 32'h1 < s_q.cfg.hevents
        |=> !out_start_at_trigger_point_out && s_q.hcnt == $past(s_q.hcnt) + 32'h1)
        else $error("event holdoff passed early");
    chk_rand_ceiling: assert property (
        s_q.cfg.hmode == HM_RANDOM && accept && min_c <= max_c |=> s_q.htmr < $past(max_c))
        else $error("random holdoff above maximum");
    chk_rand_floor: assert property (
        s_q.cfg.hmode == HM_RANDOM && accept |=> s_q.htmr + 32'h1 >= $past(min_c))
        else $error("random holdoff below minimum");
    chk_out_gate: assert property (
        !s_q.cfg.oen |=> s_q.ost == OST_IDLE && out_start_at_trigger_point_out_pin == s_q.cfg.opol)
        else $error("pulse while output disabled");
    chk_wait_start: assert property (
        s_q.cfg.osrc == OS_WAIT && acq_wait && !s_q.acq_prev && s_q.ost == OST_IDLE
        && s_q.cfg.oen |=> s_q.ost == OST_DELAY)
        else $error("wait start missed");
    chk_delay_load: assert property (
        s_q.ost == OST_IDLE && start && s_q.cfg.oen
        |=> s_q.ocnt == dly_c - 32'h1 && s_q.ocnt >= DLY_MIN_CYC - 32'h1)
        else $error("delay count wrong");
    chk_pulse_end: assert property (
        s_q.ost == OST_DELAY && s_q.ocnt == 32'h0 && s_q.cfg.oen
        |=> s_q.ost == OST_PULSE && s_q.ocnt == len_c - 32'h1)
        else $error("pulse length count wrong");
    chk_pin_level: assert property (
        s_q.ost == OST_DELAY && s_q.ocnt == 32'h0 && s_q.cfg.oen && !wr_go
        |=> (s_q.cfg.opol ? $fell(out_start_at_trigger_point_out_pin) : $rose(out_start_at_trigger_point_out_pin)))
        else $error("first pulse edge in wrong direction");

    // holdoff gate seen from the trigger side
    chk_event_pass: assert property (
        s_q.cfg.hmode == HM_EVENTS && out_start_at_trigger_point_in
        && s_q.hcnt + 32'h1 >= s_q.cfg.hevents |=> out_start_at_trigger_point_out && s_q.hcnt == 32'h0)
        else $error("event holdoff missed its count");
    chk_hold_expiry: assert property (
        s_q.cfg.hmode inside {HM_TIME, HM_RANDOM, HM_AUTO} && s_q.htmr == 32'h0
        && out_start_at_trigger_point_in |=> out_start_at_trigger_point_out)
        else $error("trigger lost after holdoff ran out");
    chk_hold_countdown: assert property (
        s_q.htmr != 32'h0 && !accept |=> s_q.htmr == $past(s_q.htmr) - 32'h1)
        else $error("holdoff timer not counting down");

    // pulse generator sequencing
    chk_out_start_at_trigger_point_start: assert property (
        s_q.cfg.osrc == OUT_START_AT_TRIGGER_POINT && accept && s_q.ost == OST_IDLE
        && s_q.cfg.oen |=> s_q.ost == OST_DELAY)
        else $error("trigger point start missed");
    chk_post_start: assert property (
        s_q.cfg.osrc == OS_POST && post_done && s_q.ost == OST_IDLE
        && s_q.cfg.oen |=> s_q.ost == OST_DELAY)
        else $error("post-trigger start missed");
    chk_delay_run: assert property (
        s_q.ost == OST_DELAY && s_q.ocnt != 32'h0 && s_q.cfg.oen
        |=> s_q.ost == OST_DELAY && s_q.ocnt == $past(s_q.ocnt) - 32'h1)
        else $error("delay count disturbed");
    chk_pulse_stop: assert property (
        s_q.ost == OST_PULSE && s_q.ocnt == 32'h0 |=> s_q.ost == OST_IDLE)
        else $error("pulse ran past its length");
endmodule
`default_nettype wire

// ---- testbench/tho_pulse_probe.sv ----
// Purpose: rear connector probe timing trigger-out pulses
// Assumes: pol is the idle level of the pin
// Notes: reset masks the step when the idle level changes
`timescale 1ns/1ps
`default_nettype none
module tho_pulse_probe
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pin,
    input wire logic pol,
    input wire logic [31:0] now,
    output logic done,
    output logic [31:0] lead,
    output logic [31:0] width
);
    logic act_q;
    logic act;

    // active is any stretch away from idle, so polarity only flips the sense
    assign act = pin ^ pol;

    // done follows the trailing edge; lead and width hold until the next pulse
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            act_q <= 1'h0;
            done <= 1'h0;
            lead <= 32'h0;
            width <= 32'h0;
        end
        else
        begin
            act_q <= act;
            done <= act_q && !act;
            if (act && !act_q)
                lead <= now;
            width <= !act ? width : act_q ? width + 32'h1 : 32'h1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tho_trigger_qual_tb.sv ----
// Purpose: self-checking bench for trigger holdoff and trigger-out pulse
// Assumes: times in 4 ns units, one wait state per bus access
// Notes: expected gaps and pulse timings wait in queues for the monitor
`timescale 1ns/1ps
`default_nettype none
module tho_trigger_qual_tb import tho_pkg::*;;
    logic sys_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic out_start_at_trigger_point_in = 1'h0, acq_wait = 1'h0, post_done = 1'h0, pol = 1'h0;
    logic probe_rstn = 1'h0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, p_lead, p_width;
    logic avs_waitrequest, out_start_at_trigger_point_out, out_start_at_trigger_point_out_pin, p_done;
    int cyc = 0, last_out = 0, n_mismatch = 0, compares = 0;
    int lo_q[$], hi_q[$], pl_q[$], pw_q[$];
    logic [31:0] rd_q[$];

    // 200 MHz clock and a cycle stamp shared with the probe
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        cyc <= cyc + 1;

    tho_trigger_qual u_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .out_start_at_trigger_point_in(out_start_at_trigger_point_in), .acq_wait(acq_wait),
        .post_done(post_done), .out_start_at_trigger_point_out(out_start_at_trigger_point_out), .out_start_at_trigger_point_out_pin(out_start_at_trigger_point_out_pin));
    tho_pulse_probe u_probe (.sys_clk(sys_clk), .rstn(probe_rstn), .pin(out_start_at_trigger_point_out_pin),
        .pol(pol), .now(32'(cyc)), .done(p_done), .lead(p_lead), .width(p_width));

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until waitrequest is sampled low; bounded so a dead slave shows
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'h0 && n < 50);
        if (n >= 50)
            chk("bus_answer", 32'h0, 32'h1);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'h1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'h0, a, 32'h0, 4'hF);
    endtask

    // judged on pre-edge values, so process order at the edge never matters
    always @(posedge sys_clk)
    begin
        int lo;
        int hi;
        int g;
        if (avs_read === 1'h1 && avs_waitrequest === 1'h0 && rd_q.size() > 0)
            chk("readdata", rd_q.pop_front(), avs_readdata);
        if (out_start_at_trigger_point_out === 1'h1)
        begin
            chk("trigger_expected", 32'h1, 32'(lo_q.size() > 0));
            if (lo_q.size() > 0)
            begin
                lo = lo_q.pop_front();
                hi = hi_q.pop_front();
                g = cyc - last_out;
                if (g > lo && g <= hi)
                    g = lo;
                chk("trigger_gap", 32'(lo), 32'(g));
            end
            last_out = cyc;
        end
        if (p_done === 1'h1)
        begin
            chk("pulse_expected", 32'h1, 32'(pl_q.size() > 0));
            if (pl_q.size() > 0)
            begin
                chk("pulse_lead", 32'(pl_q.pop_front()), p_lead);
                chk("pulse_width", 32'(pw_q.pop_front()), p_width);
            end
        end
    end

    // event line stays high, so every event inside the holdoff must be dropped
    task automatic burst(input int lim, input int first, input int lo, input int hi,
        input int cnt);
        @(posedge sys_clk);
        lo_q.push_back(cyc + 2 + first - last_out);
        hi_q.push_back(cyc + 2 + first - last_out);
        for (int k = 1; k < cnt; k++)
        begin
            lo_q.push_back(lo);
            hi_q.push_back(hi);
        end
        out_start_at_trigger_point_in <= 1'h1;
        for (int k = 0; k < lim && lo_q.size() > 0; k++)
            @(posedge sys_clk);
        out_start_at_trigger_point_in <= 1'h0;
        repeat (40) @(posedge sys_clk);
    endtask

    // out_start_at_trigger_point_in fires a cycle before the other starts, so a wrong source shows in the lead
    task automatic pulse_run(input int src, input logic pl, input int od, input int ln,
        input logic en);
        int d;
        d = (8 * od + 5) / 10 < 120 ? 120 : (8 * od + 5) / 10;
        probe_rstn <= 1'h0;
        wr(A_ODELAY, 32'(od));
        wr(A_OPLEN, 32'(ln));
        wr(A_CTRL, {25'h0, pl, 2'(src), en, 3'h0});
        pol <= pl;
        repeat (4) @(posedge sys_clk);
        probe_rstn <= 1'h1;
        @(posedge sys_clk);
        if (en)
        begin
            pl_q.push_back(cyc + d + ((src == 0) ? 2 : 3));
            pw_q.push_back((8 * ln + 5) / 10);
        end
        lo_q.push_back(cyc + 2 - last_out);
        hi_q.push_back(cyc + 2 - last_out);
        out_start_at_trigger_point_in <= 1'h1;
        @(posedge sys_clk);
        out_start_at_trigger_point_in <= 1'h0;
        acq_wait <= (src == 1);
        post_done <= (src == 2);
        @(posedge sys_clk);
        acq_wait <= 1'h0;
        post_done <= 1'h0;
        repeat (d + 40) @(posedge sys_clk);
    endtask

    // reset values, refusals, each holdoff method, then the output pulse
    initial
    begin
        int t;
        void'($urandom(83));
        repeat (4) @(posedge sys_clk);
        rstn <= 1'h1;
        chk("idle_pin", 32'h0, 32'(out_start_at_trigger_point_out_pin));
        rd(A_CTRL, 32'h0);
        rd(A_HTIME, RST_HTIME);
        rd(A_HEVENTS, RST_HEVENTS);
        rd(A_HMAX, RST_HMAX);
        rd(A_HMIN, RST_HMIN);
        rd(A_HFACT, RST_HFACT);
        rd(A_HSCALE, RST_HSCALE);
        rd(A_ODELAY, RST_ODELAY);
        rd(A_OPLEN, RST_OPLEN);
        rd(A_STATUS, 32'h0);
        bus(1'h1, A_HTIME, 32'hFFFFFFFF, 4'h1);
        rd(A_HTIME, {RST_HTIME[31:8], 8'hFF});
        wr(6'h28, 32'hFFFFFFFF);
        rd(6'h28, 32'h0);
        bus(1'h1, A_CTRL, 32'h0000004F, 4'hE);
        rd(A_CTRL, 32'h0);
        wr(A_HEVENTS, 32'h3);
        wr(A_CTRL, 32'h2);
        burst(2000, 2, 3, 3, 4);
        for (int i = 0; i < 3; i++)
        begin
            t = (i == 0) ? 11 : (i == 1) ? 9 : $urandom_range(40, 5);
            wr(A_HTIME, 32'(t));
            wr(A_CTRL, 32'h1);
            burst(2000, 0, (8 * t + 5) / 10, (8 * t + 5) / 10, 4);
        end
        wr(A_HMIN, 32'hA);
        wr(A_HMAX, 32'h14);
        wr(A_CTRL, 32'h3);
        burst(2000, 0, 8, 16, 12);
        wr(A_HFACT, 32'h5DC);
        wr(A_HSCALE, 32'h5);
        wr(A_CTRL, 32'h4);
        burst(2000, 0, 6, 6, 4);
        wr(A_CTRL, 32'h0);
        burst(5, 0, 1, 1, 5);
        for (int i = 0; i < 4; i++)
            pulse_run(i % 3, i == 1, (i == 3) ? 100 : 201, $urandom_range(10, 1), 1'h1);
        pulse_run(0, 1'h0, 201, 4, 1'h0);
        chk("trigger_left", 32'h0, 32'(lo_q.size()));
        chk("pulse_left", 32'h0, 32'(pl_q.size()));
        complete_run();
    end

    // cut a hang short; the planned run is far below this span
    initial
    begin
        #400000;
        chk("run_time", 32'h0, 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire
